// [inc/ddma_defines.vh]
// constants and bit layouts for the descriptor dma host master
// Functional notes
// - Two separate descriptor lists, receive and transmit, both kept in host memory.
// - Each list walk starts from rx_list_base or tx_list_base as software wrote it.
// - Lists go forward only: next descriptor sequential or by stored pointer.
// - A ring end flag makes the next fetch wrap to the list base.
// - Chained flag turns the second address into the next descriptor pointer.
// - Up to two buffers per descriptor, own size and address, not contiguous.
// - A buffer holds at most one frame; status goes only into the descriptor.
// - A frame may span several descriptors only while data chaining is enabled.
// - After an early collision, retransmit once defer then backoff have elapsed.
// - single_cmd_flag is high while a single-beat command is on master_command.
// - A command is held until slave_data_valid or slave_error is sampled.
// - On the response the next pending command loads at once, else idle.
// - slave_error ends the command and the failure is reported; an error answering a command while in S_BOFF sets no DDMA_S_BUSERR bit.
// - Master address, write data and slave read data are 32 bits wide.
// - All host events share one interrupt output.
// - Byte order of moved data words is selectable big or little endian.
// - Words per burst are set by software.
`ifndef DDMA_DEFINES_VH
`define DDMA_DEFINES_VH
`define DDMA_CMD_IDLE   2'h0
`define DDMA_CMD_READ   2'h1
`define DDMA_CMD_WRITE  2'h2
`define DDMA_REG_CTRL   8'h00
`define DDMA_REG_STAT   8'h04
`define DDMA_REG_RXBASE 8'h08
`define DDMA_REG_TXBASE 8'h0C
`define DDMA_REG_RXCUR  8'h10
`define DDMA_REG_TXCUR  8'h14
`define DDMA_CTRL_RST   32'h00000100
`define DDMA_C_RXEN     0
`define DDMA_C_TXEN     1
`define DDMA_C_CHAIN    2
`define DDMA_C_BIGEND   3
`define DDMA_C_BURST    13:8
`define DDMA_C_SPEED    17:16
`define DDMA_STAT_W     7
`define DDMA_S_RXDONE   0
`define DDMA_S_TXDONE   1
`define DDMA_S_BUSERR   2
`define DDMA_S_RXUNAV   3
`define DDMA_S_TXUNAV   4
`define DDMA_S_RXOVF    5
`define DDMA_S_RETRY    6
`define DDMA_D_OWN      31
`define DDMA_D_LAST     30
`define DDMA_D_RING     25
`define DDMA_D_CHAINED  24
`define DDMA_D_SZ1      10:0
`define DDMA_D_SZ2      21:11
`define DDMA_D_STEP     32'h00000010
`define DDMA_D_W1       32'h00000004
`define DDMA_D_W2       32'h00000008
`define DDMA_D_W3       32'h0000000C
`define DDMA_WORD_BYTES 32'h00000004
`define DDMA_WB_ERR     15
`define DDMA_WB_LAST    14
`define DDMA_SPD_10     2'h0
`define DDMA_SPD_100    2'h1
`define DDMA_CLK_NS     100
`define DDMA_DEFER_BITS 96
`define DDMA_SLOT_BITS  512
`define DDMA_GSLOT_BITS 4096
`define DDMA_BT10_NS    100
`define DDMA_BT100_NS   10
`define DDMA_BT1G_NS    1
`define DDMA_BO_LIMIT   4'hA
`define DDMA_LFSR_SEED  10'h1A5
`endif

// [logic/ddma_master.v]
// single-beat host bus master: holds a command until the slave answers
`include "ddma_defines.vh"
module ddma_master (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        push,
  input  wire        push_wr,
  input  wire [31:0] push_addr,
  input  wire [31:0] push_data,
  output reg  [1:0]  master_command,
  output reg  [31:0] master_address,
  output reg  [31:0] master_write_data,
  output reg         single_cmd_flag,
  input  wire [31:0] slave_read_data,
  input  wire        slave_data_valid,
  input  wire        slave_error,
  output wire        resp_ok,
  output wire        resp_err,
  output wire [31:0] resp_data
);
  wire active = (master_command != `DDMA_CMD_IDLE);
  wire resp   = active && (slave_data_valid || slave_error);
  assign resp_err  = resp && slave_error;
  assign resp_ok   = resp && !slave_error;
  assign resp_data = slave_read_data;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      master_command    <= `DDMA_CMD_IDLE;
      master_address    <= 32'h00000000;
      master_write_data <= 32'h00000000;
      single_cmd_flag   <= 1'b0;
    end else if (ce) begin
      if ((resp || !active) && push) begin
        master_command    <= push_wr ? `DDMA_CMD_WRITE : `DDMA_CMD_READ;
        master_address    <= push_addr;
        master_write_data <= push_data;
        single_cmd_flag   <= 1'b1;
      end else if (resp) begin
        master_command  <= `DDMA_CMD_IDLE;
        single_cmd_flag <= 1'b0;
      end
    end
  end
endmodule

// [logic/ddma_backoff.v]
// defer plus random slot backoff timer for collision retries
`include "ddma_defines.vh"
module ddma_backoff (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       ce,
  input  wire       start,
  input  wire [1:0] speed,
  input  wire [3:0] attempt,
  output reg        done
);
  function [19:0] cyc;
    input [31:0] ns;
    reg   [31:0] q;
    begin
      q = (ns + `DDMA_CLK_NS - 1) / `DDMA_CLK_NS;
      cyc = (q == 32'h00000000) ? 20'h00001 : q[19:0];
    end
  endfunction
  wire [19:0] defer_cyc = (speed == `DDMA_SPD_10)  ? cyc(`DDMA_DEFER_BITS * `DDMA_BT10_NS) :
                          (speed == `DDMA_SPD_100) ? cyc(`DDMA_DEFER_BITS * `DDMA_BT100_NS) :
                                                     cyc(`DDMA_DEFER_BITS * `DDMA_BT1G_NS);
  wire [19:0] slot_cyc  = (speed == `DDMA_SPD_10)  ? cyc(`DDMA_SLOT_BITS * `DDMA_BT10_NS) :
                          (speed == `DDMA_SPD_100) ? cyc(`DDMA_SLOT_BITS * `DDMA_BT100_NS) :
                                                     cyc(`DDMA_GSLOT_BITS * `DDMA_BT1G_NS);
  // truncated binary exponential window, capped at ten doublings
  wire [3:0]  expo = (attempt > `DDMA_BO_LIMIT) ? `DDMA_BO_LIMIT : attempt;
  wire [9:0]  mask = ~(10'h3FF << expo);
  reg  [9:0]  lfsr;
  reg  [9:0]  slots;
  reg  [19:0] cnt;
  reg         run;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr <= `DDMA_LFSR_SEED;
      slots <= 10'h000;
      cnt <= 20'h00000;
      run <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      lfsr <= {lfsr[8:0], lfsr[9] ^ lfsr[6]};
      done <= 1'b0;
      if (start) begin
        run <= 1'b1;
        cnt <= defer_cyc - 20'h00001;
        slots <= lfsr & mask;
      end else if (run) begin
        if (cnt != 20'h00000) begin
          cnt <= cnt - 20'h00001;
        end else if (slots == 10'h000) begin
          run <= 1'b0;
          done <= 1'b1;
        end else begin
          slots <= slots - 10'h001;
          cnt <= slot_cyc - 20'h00001;
        end
      end
    end
  end
endmodule

// [logic/ddma_top.v]
// descriptor walking dma engine with register port and host master
//
// Local design decisions: the register offsets and the address-and-strobe port.
`include "ddma_defines.vh"
module ddma_top (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output wire [1:0]  master_command,
  output wire [31:0] master_address,
  output wire [31:0] master_write_data,
  output wire        single_cmd_flag,
  input  wire [31:0] slave_read_data,
  input  wire        slave_data_valid,
  input  wire        slave_error,
  input  wire [31:0] rx_word,
  input  wire        rx_word_last,
  input  wire        rx_word_valid,
  output reg         rx_word_take,
  output reg  [31:0] tx_word,
  output reg         tx_word_last,
  output reg         tx_word_valid,
  input  wire        tx_word_ready,
  input  wire        tx_early_col,
  output reg         host_int
);
  localparam S_IDLE = 4'h0;
  localparam S_OWN  = 4'h1;
  localparam S_CTL  = 4'h2;
  localparam S_B1   = 4'h3;
  localparam S_B2   = 4'h4;
  localparam S_XFER = 4'h5;
  localparam S_WB   = 4'h6;
  localparam S_BOFF = 4'h7;
  localparam S_DROP = 4'h8;
  localparam DIR_RX = 1'b0;
  localparam DIR_TX = 1'b1;

  function [31:0] order;
    input [31:0] d;
    input        big;
    begin
      order = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
    end
  endfunction
  function [9:0] nwords;
    input [10:0] bytes;
    begin
      nwords = {1'b0, bytes[10:2]} + {9'h000, |bytes[1:0]};
    end
  endfunction

  reg  [31:0] ctrl;
  reg  [31:0] rx_base;
  reg  [31:0] tx_base;
  reg  [31:0] rx_cur;
  reg  [31:0] tx_cur;
  reg  [`DDMA_STAT_W-1:0] stat;
  reg  [3:0]  st;
  reg         dir;
  reg         busy;
  reg         gap;
  reg         buf_sel;
  reg         retry;
  reg         in_frame;
  reg         frame_last;
  reg         rx_hold_last;
  reg         bo_ok;
  reg  [31:0] desc_addr;
  reg  [31:0] dctl;
  reg  [31:0] b2;
  reg  [31:0] buf_addr;
  reg  [31:0] frame_start;
  reg  [9:0]  words_left;
  reg  [11:0] xfer_cnt;
  reg  [5:0]  burst_cnt;
  reg  [3:0]  attempt;
  reg         push;
  reg         push_wr;
  reg  [31:0] push_addr;
  reg  [31:0] push_data;
  wire        resp_ok;
  wire        resp_err;
  wire [31:0] rd;
  wire        bo_done;

  wire        big      = ctrl[`DDMA_C_BIGEND];
  wire        chain_en = ctrl[`DDMA_C_CHAIN];
  wire [5:0]  blen     = ctrl[`DDMA_C_BURST];
  wire [10:0] sz2      = dctl[`DDMA_D_SZ2];
  wire        chained  = dctl[`DDMA_D_CHAINED];
  wire        last_buf = buf_sel || chained || (sz2 == 11'h000);
  // without data chaining a descriptor always closes the frame
  wire        tx_final = (words_left == 10'h001) && last_buf &&
                         (dctl[`DDMA_D_LAST] || !chain_en);
  wire        trunc    = !frame_last && !chain_en;
  wire [31:0] wb_word  = ({31'h0, frame_last} << `DDMA_WB_LAST) |
                         ({31'h0, trunc} << `DDMA_WB_ERR) | {18'h0, xfer_cnt, 2'h0};
  wire [31:0] list_base = (dir == DIR_TX) ? tx_base : rx_base;
  wire [31:0] next_desc = dctl[`DDMA_D_RING] ? list_base :
                          chained ? b2 :
                          desc_addr + `DDMA_D_STEP;
  wire        drop_take = (st == S_DROP) && rx_word_valid && !rx_word_take;
  wire        col_hit   = tx_early_col && (dir == DIR_TX) && in_frame &&
                          (st != S_IDLE) && (st != S_BOFF);
  wire        burst_end = ({2'h0, burst_cnt} + 8'h01 >= {2'h0, blen});

  always @* begin
    push = 1'b0;
    push_wr = 1'b0;
    push_addr = desc_addr;
    push_data = 32'h00000000;
    if (!busy) begin
      case (st)
        S_OWN: push = 1'b1;
        S_CTL: begin
          push = 1'b1;
          push_addr = desc_addr + `DDMA_D_W1;
        end
        S_B1: begin
          push = 1'b1;
          push_addr = desc_addr + `DDMA_D_W2;
        end
        S_B2: begin
          push = 1'b1;
          push_addr = desc_addr + `DDMA_D_W3;
        end
        S_XFER: begin
          push_addr = buf_addr;
          if (!gap && (words_left != 10'h000)) begin
            if (dir == DIR_RX) begin
              push = rx_word_valid && !rx_word_take;
              push_wr = 1'b1;
              push_data = order(rx_word, big);
            end else begin
              push = !tx_word_valid;
            end
          end
        end
        S_WB: begin
          push = 1'b1;
          push_wr = 1'b1;
          push_data = wb_word;
        end
        default: push = 1'b0;
      endcase
    end
  end

  ddma_master u_master (
    .clk               (clk),
    .rst_n             (rst_n),
    .ce                (ce),
    .push              (push),
    .push_wr           (push_wr),
    .push_addr         (push_addr),
    .push_data         (push_data),
    .master_command    (master_command),
    .master_address    (master_address),
    .master_write_data (master_write_data),
    .single_cmd_flag   (single_cmd_flag),
    .slave_read_data   (slave_read_data),
    .slave_data_valid  (slave_data_valid),
    .slave_error       (slave_error),
    .resp_ok           (resp_ok),
    .resp_err          (resp_err),
    .resp_data         (rd)
  );

  ddma_backoff u_backoff (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .start   (col_hit),
    .speed   (ctrl[`DDMA_C_SPEED]),
    .attempt (attempt),
    .done    (bo_done)
  );

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `DDMA_REG_CTRL:   reg_rdata <= ctrl;
          `DDMA_REG_STAT:   reg_rdata <= {12'h000, st, 9'h000, stat};
          `DDMA_REG_RXBASE: reg_rdata <= rx_base;
          `DDMA_REG_TXBASE: reg_rdata <= tx_base;
          `DDMA_REG_RXCUR:  reg_rdata <= rx_cur;
          `DDMA_REG_TXCUR:  reg_rdata <= tx_cur;
          default:          reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DDMA_CTRL_RST;
      rx_base <= 32'h00000000;
      tx_base <= 32'h00000000;
      rx_cur <= 32'h00000000;
      tx_cur <= 32'h00000000;
      stat <= {`DDMA_STAT_W{1'b0}};
      host_int <= 1'b0;
      st <= S_IDLE;
      dir <= DIR_RX;
      busy <= 1'b0;
      gap <= 1'b0;
      buf_sel <= 1'b0;
      retry <= 1'b0;
      in_frame <= 1'b0;
      frame_last <= 1'b0;
      rx_hold_last <= 1'b0;
      bo_ok <= 1'b0;
      desc_addr <= 32'h00000000;
      dctl <= 32'h00000000;
      b2 <= 32'h00000000;
      buf_addr <= 32'h00000000;
      frame_start <= 32'h00000000;
      words_left <= 10'h000;
      xfer_cnt <= 12'h000;
      burst_cnt <= 6'h00;
      attempt <= 4'h0;
      rx_word_take <= 1'b0;
      tx_word <= 32'h00000000;
      tx_word_last <= 1'b0;
      tx_word_valid <= 1'b0;
    end else if (ce) begin
      host_int <= |stat;
      rx_word_take <= (push && (st == S_XFER) && (dir == DIR_RX)) || drop_take;
      gap <= 1'b0;
      if (tx_word_valid && tx_word_ready) begin
        tx_word_valid <= 1'b0;
      end
      if (reg_wr) begin
        case (reg_addr)
          `DDMA_REG_CTRL: ctrl <= reg_wdata;
          `DDMA_REG_STAT: stat <= stat & ~reg_wdata[`DDMA_STAT_W-1:0];
          default: ;
        endcase
      end
      if (push) begin
        busy <= 1'b1;
        if (st == S_XFER) begin
          rx_hold_last <= rx_word_last;
          burst_cnt <= burst_end ? 6'h00 : burst_cnt + 6'h01;
          gap <= burst_end;
        end
      end
      if (resp_ok || resp_err) begin
        busy <= 1'b0;
      end
      if (bo_done) begin
        bo_ok <= 1'b1;
      end
      if (resp_err && (st != S_BOFF)) begin
        stat[`DDMA_S_BUSERR] <= 1'b1;
        st <= S_IDLE;
        in_frame <= 1'b0;
        frame_last <= 1'b0;
      end else begin
        case (st)
          S_IDLE: if (!busy) begin
            retry <= 1'b0;
            attempt <= 4'h0;
            if (ctrl[`DDMA_C_RXEN] && rx_word_valid && !rx_word_take) begin
              dir <= DIR_RX;
              desc_addr <= rx_cur;
              st <= S_OWN;
              in_frame <= 1'b1;
            end else if (ctrl[`DDMA_C_TXEN]) begin
              dir <= DIR_TX;
              desc_addr <= tx_cur;
              frame_start <= tx_cur;
              st <= S_OWN;
              in_frame <= 1'b1;
            end
          end
          S_OWN: if (resp_ok) begin
            if (rd[`DDMA_D_OWN] || retry) begin
              st <= S_CTL;
            end else begin
              stat[(dir == DIR_TX) ? `DDMA_S_TXUNAV : `DDMA_S_RXUNAV] <= 1'b1;
              st <= S_IDLE;
              in_frame <= 1'b0;
            end
          end
          S_CTL: if (resp_ok) begin
            dctl <= rd;
            st <= S_B1;
          end
          S_B1: if (resp_ok) begin
            buf_addr <= rd;
            st <= S_B2;
          end
          S_B2: if (resp_ok) begin
            b2 <= rd;
            buf_sel <= 1'b0;
            words_left <= nwords(dctl[`DDMA_D_SZ1]);
            xfer_cnt <= 12'h000;
            burst_cnt <= 6'h00;
            st <= S_XFER;
          end
          S_XFER: begin
            if (resp_ok) begin
              buf_addr <= buf_addr + `DDMA_WORD_BYTES;
              words_left <= words_left - 10'h001;
              xfer_cnt <= xfer_cnt + 12'h001;
              if (dir == DIR_TX) begin
                tx_word <= order(rd, big);
                tx_word_valid <= 1'b1;
                tx_word_last <= tx_final;
                if (tx_final) begin
                  frame_last <= 1'b1;
                  st <= S_WB;
                end
              end else if (rx_hold_last) begin
                frame_last <= 1'b1;
                st <= S_WB;
              end
            end else if (!busy && (words_left == 10'h000)) begin
              if (!buf_sel && !chained && (sz2 != 11'h000)) begin
                buf_sel <= 1'b1;
                buf_addr <= b2;
                words_left <= nwords(sz2);
              end else begin
                st <= S_WB;
              end
            end
          end
          S_WB: if (resp_ok) begin
            desc_addr <= next_desc;
            if (dir == DIR_TX) begin
              tx_cur <= next_desc;
            end else begin
              rx_cur <= next_desc;
            end
            if (frame_last) begin
              stat[(dir == DIR_TX) ? `DDMA_S_TXDONE : `DDMA_S_RXDONE] <= 1'b1;
              frame_last <= 1'b0;
              in_frame <= 1'b0;
              st <= S_IDLE;
            end else if (chain_en) begin
              st <= S_OWN;
            end else begin
              in_frame <= 1'b0;
              st <= (dir == DIR_TX) ? S_IDLE : S_DROP;
              if (dir == DIR_RX) begin
                stat[`DDMA_S_RXOVF] <= 1'b1;
              end
            end
          end
          S_BOFF: if (bo_ok && !busy) begin
            bo_ok <= 1'b0;
            retry <= 1'b1;
            desc_addr <= frame_start;
            st <= S_OWN;
          end
          S_DROP: if (drop_take && rx_word_last) begin
            st <= S_IDLE;
          end
          default: st <= S_IDLE;
        endcase
      end
      if (col_hit) begin
        st <= S_BOFF;
        bo_ok <= 1'b0;
        frame_last <= 1'b0;
        tx_word_valid <= 1'b0;
        stat[`DDMA_S_RETRY] <= 1'b1;
        attempt <= (attempt == 4'hF) ? attempt : attempt + 4'h1;
      end
      if (reg_wr && (reg_addr == `DDMA_REG_RXBASE)) begin
        rx_base <= reg_wdata;
        rx_cur <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `DDMA_REG_TXBASE)) begin
        tx_base <= reg_wdata;
        tx_cur <= reg_wdata;
      end
    end
  end
endmodule

// [dv/ddma_mem.sv]
// host memory slave model answering single commands of the dma master
`include "ddma_defines.vh"
module ddma_mem (
  input  logic        clk,
  input  logic        rst_n,
  input  logic [1:0]  master_command,
  input  logic [31:0] master_address,
  input  logic [31:0] master_write_data,
  input  logic [3:0]  lat,
  input  logic [31:0] err_addr,
  output logic [31:0] slave_read_data,
  output logic        slave_data_valid,
  output logic        slave_error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [0:255];
  logic [3:0]  cnt;
  wire         busy = master_command != `DDMA_CMD_IDLE && !slave_data_valid && !slave_error;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  // word index only: software keeps everything word aligned
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      slave_data_valid <= 1'h0;
      slave_error <= 1'h0;
      slave_read_data <= 32'h0;
    end else begin
      slave_data_valid <= 1'h0;
      slave_error <= 1'h0;
      // released data toggles so a stale word never looks valid
      slave_read_data <= ~slave_read_data;
      if (busy && cnt != lat) cnt <= cnt + 4'h1;
      else if (busy) begin
        cnt <= 4'h0;
        if (master_address == err_addr) slave_error <= 1'h1;
        else begin
          slave_data_valid <= 1'h1;
          if (master_command == `DDMA_CMD_READ) slave_read_data <= mem[master_address[9:2]];
          if (master_command == `DDMA_CMD_WRITE) mem[master_address[9:2]] <= master_write_data;
        end
      end
    end
  end
endmodule

// [dv/ddma_top_props.sv]
// port assertions for the descriptor dma top
`include "ddma_defines.vh"
module ddma_top_props (
  input wire        clk,
  input wire        rst_n,
  input wire        ce,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire [1:0]  master_command,
  input wire [31:0] master_address,
  input wire [31:0] master_write_data,
  input wire        single_cmd_flag,
  input wire        slave_data_valid,
  input wire        slave_error,
  input wire [31:0] tx_word,
  input wire        tx_word_valid,
  input wire        tx_word_ready,
  input wire        tx_early_col
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wait;
    master_command != `DDMA_CMD_IDLE && !slave_data_valid && !slave_error;
  endsequence
  sequence s_resp;
    ce && master_command != `DDMA_CMD_IDLE && (slave_data_valid || slave_error);
  endsequence
  cmd_held_a: assert property (s_wait |=>
    $stable({master_command, master_address, master_write_data}))
    else $error("command moved before the slave answered");
  cmd_idle_a: assert property (s_resp |=> master_command == `DDMA_CMD_IDLE)
    else $error("command not released after the answer");
  flag_match_a: assert property (single_cmd_flag == (master_command != `DDMA_CMD_IDLE))
    else $error("single flag disagrees with command");
  cmd_code_a: assert property (master_command != 2'h3)
    else $error("undefined command code");
  addr_align_a: assert property (s_wait |-> master_address[1:0] == 2'h0)
    else $error("unaligned master address");
  rdata_zero_a: assert property (!$past(reg_rd && ce) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");
  tx_hold_a: assert property (tx_word_valid && !tx_word_ready && !tx_early_col |=>
    tx_word_valid && $stable(tx_word))
    else $error("tx word withdrawn before ready");
  col_drop_a: assert property (tx_early_col && tx_word_valid |=> !tx_word_valid)
    else $error("tx word kept after collision");
endmodule
bind ddma_top ddma_top_props ddma_top_props_i (.clk, .rst_n, .ce, .reg_rd, .reg_rdata,
  .master_command, .master_address, .master_write_data, .single_cmd_flag, .slave_data_valid,
  .slave_error, .tx_word, .tx_word_valid, .tx_word_ready, .tx_early_col);

// [dv/ddma_top_tb.sv]
// self-checking bench for the descriptor dma top
`include "ddma_defines.vh"
module ddma_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'h0;
  logic        rst_n, ce, reg_wr, reg_rd, rx_word_last, rx_word_valid, tx_word_ready, tx_early_col;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, rx_word, err_addr;
  logic [3:0]  lat;
  wire  [31:0] reg_rdata, master_address, master_write_data, slave_read_data, tx_word;
  wire  [1:0]  master_command;
  wire         single_cmd_flag, slave_data_valid, slave_error, rx_word_take, tx_word_last;
  wire         tx_word_valid, host_int;
  int          n_fail = 0;
  int          compares = 0;
  ddma_top ddma_top_i (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .master_command, .master_address, .master_write_data, .single_cmd_flag, .slave_read_data,
    .slave_data_valid, .slave_error, .rx_word, .rx_word_last, .rx_word_valid, .rx_word_take,
    .tx_word, .tx_word_last, .tx_word_valid, .tx_word_ready, .tx_early_col, .host_int);
  ddma_mem mem_i (.clk, .rst_n, .master_command, .master_address, .master_write_data, .lat,
    .err_addr, .slave_read_data, .slave_data_valid, .slave_error);
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata & m, exp);
    @(posedge clk);
  endtask
  // bounded wait: 0 tx valid, 1 rx take, 2 interrupt
  task automatic wait_sig(input int k);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      #1;
      if (k == 0 && tx_word_valid === 1'h1 || k == 1 && rx_word_take === 1'h1) break;
      if (k == 2 && host_int === 1'h1) break;
    end
    if (i == 2000) chk(32'h0, 32'h1);
  endtask
  task automatic get_tx(input logic [31:0] w, input logic l);
    wait_sig(0);
    chk(tx_word, w);
    chk({31'h0, tx_word_last}, {31'h0, l});
    @(posedge clk);
    tx_word_ready <= 1'h1;
    @(posedge clk);
    tx_word_ready <= 1'h0;
  endtask
  // leaves valid up so the next word follows at the take edge
  task automatic put_rx(input logic [31:0] w, input logic l);
    rx_word <= w;
    rx_word_last <= l;
    rx_word_valid <= 1'h1;
    wait_sig(1);
    @(posedge clk);
  endtask
  task automatic put_desc(input logic [31:0] a, w0, w1, w2, w3);
    mem_i.mem[a[9:2]] = w0;
    mem_i.mem[a[9:2] + 8'h1] = w1;
    mem_i.mem[a[9:2] + 8'h2] = w2;
    mem_i.mem[a[9:2] + 8'h3] = w3;
  endtask
  task automatic wait_wb(input logic [31:0] a);
    int i;
    for (i = 0; i < 2000 && mem_i.mem[a[9:2]][31] !== 1'h0; i++) @(posedge clk);
    if (i == 2000) chk(32'h0, 32'h1);
  endtask
  task automatic t_regs;
    rd(8'h00, 32'h00000100, 32'hFFFFFFFF);
    rd(8'h20, 32'h00000000, 32'hFFFFFFFF);
    wr(8'h0C, 32'h00000100);
    wr(8'h14, 32'h00000300);
    rd(8'h0C, 32'h00000100, 32'hFFFFFFFF);
    rd(8'h14, 32'h00000100, 32'hFFFFFFFF);
  endtask
  // two buffers, stalled sink, collision in mid-frame at 1G, ring wrap
  task automatic t_tx;
    put_desc(32'h100, 32'h80000000, 32'h42002008, 32'h200, 32'h240);
    mem_i.mem[8'h80] = 32'hA0000001;
    mem_i.mem[8'h81] = 32'hA0000002;
    mem_i.mem[8'h90] = 32'hB0000001;
    wr(8'h00, 32'h00020202);
    rd(8'h00, 32'h00020202, 32'hFFFFFFFF);
    get_tx(32'hA0000001, 1'h0);
    wait_sig(0);
    @(posedge clk);
    tx_early_col <= 1'h1;
    @(posedge clk);
    tx_early_col <= 1'h0;
    get_tx(32'hA0000001, 1'h0);
    get_tx(32'hA0000002, 1'h0);
    get_tx(32'hB0000001, 1'h1);
    wait_wb(32'h100);
    chk(mem_i.mem[8'h40], 32'h0000400C);
    rd(8'h14, 32'h00000100, 32'hFFFFFFFF);
    rd(8'h04, 32'h00000042, 32'h00000046);
    chk({31'h0, host_int}, 32'h1);
    wr(8'h00, 32'h00000100);
  endtask
  // chained pointer wins over second buffer; big endian data
  task automatic t_chain;
    put_desc(32'h180, 32'h80000000, 32'h41002004, 32'h280, 32'h1C0);
    mem_i.mem[8'hA0] = 32'h11223344;
    wr(8'h0C, 32'h00000180);
    wr(8'h00, 32'h0000010E);
    get_tx(32'h44332211, 1'h1);
    wait_wb(32'h180);
    chk(mem_i.mem[8'h60], 32'h00004004);
    rd(8'h14, 32'h000001C0, 32'hFFFFFFFF);
    wr(8'h00, 32'h00000100);
  endtask
  // slow slave during a receive frame
  task automatic t_rx;
    lat <= 4'h3;
    put_desc(32'h300, 32'h80000000, 32'h02000008, 32'h380, 32'h0);
    wr(8'h08, 32'h00000300);
    wr(8'h00, 32'h00000101);
    put_rx(32'hC0000001, 1'h0);
    put_rx(32'hC0000002, 1'h1);
    rx_word_valid <= 1'h0;
    wait_wb(32'h300);
    chk(mem_i.mem[8'hE0], 32'hC0000001);
    chk(mem_i.mem[8'hE1], 32'hC0000002);
    chk(mem_i.mem[8'hC0], 32'h00004008);
    rd(8'h10, 32'h00000300, 32'hFFFFFFFF);
    wr(8'h00, 32'h00000100);
    lat <= 4'h0;
  endtask
  // slave refuses a data word: no write-back, status and interrupt
  task automatic t_err;
    wr(8'h04, 32'h0000007F);
    put_desc(32'h100, 32'h80000000, 32'h42002008, 32'h200, 32'h240);
    err_addr <= 32'h00000204;
    wr(8'h0C, 32'h00000100);
    wr(8'h00, 32'h00000102);
    get_tx(32'hA0000001, 1'h0);
    wait_sig(2);
    @(posedge clk);
    rd(8'h04, 32'h00000004, 32'h00000004);
    chk(mem_i.mem[8'h40], 32'h80000000);
    wr(8'h00, 32'h00000100);
    wr(8'h04, 32'h0000007F);
    rd(8'h04, 32'h00000000, 32'h0000007F);
    chk({31'h0, host_int}, 32'h0);
  endtask
  task automatic end_sim;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    {reg_wr, reg_rd, rx_word_last, rx_word_valid, tx_word_ready, tx_early_col} = 6'h0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    rx_word = 32'h0;
    lat = 4'h0;
    err_addr = 32'hFFFFFFFC;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_regs;
    t_tx;
    t_chain;
    t_rx;
    t_err;
    end_sim;
  end
  // far above the few hundred cycles the scenarios need
  initial begin
    #6000000;
    n_fail++;
    end_sim;
  end
endmodule
